// >>> design/dspm_defines.svh
// register offsets, field positions and reset values of the multiplier block
`ifndef DSPM_DEFINES_SVH
`define DSPM_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DSPM_OFF_CTRL 8'h00
`define DSPM_OFF_SETSEL 8'h04
`define DSPM_OFF_STATUS 8'h08
`define DSPM_OFF_PROD_LO 8'h0C
`define DSPM_OFF_PROD_HI 8'h10

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define DSPM_CTRL_MODE_LSB 0
`define DSPM_CTRL_MODE_MSB 1
`define DSPM_CTRL_INA 2
`define DSPM_CTRL_INB 3
`define DSPM_CTRL_SHIFT 4
`define DSPM_CTRL_PAR_A 5
`define DSPM_CTRL_PAR_B 6
`define DSPM_CTRL_PIPE 7
`define DSPM_CTRL_SIGNREG 8
`define DSPM_CTRL_SHARED 9
`define DSPM_CTRL_ROUTE 10
`define DSPM_CTRL_TAP_LSB 12
`define DSPM_CTRL_TAP_MSB 13
`define DSPM_CTRL_MASK 32'h0000_37FF

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define DSPM_CTRL_RST 32'h0000_0001
`define DSPM_SETSEL_RST 32'h0000_0000
`define DSPM_SETSEL_MASK 32'h0000_FFFF
`define DSPM_RESP_OKAY 2'h0
`define DSPM_RESP_SLVERR 2'h2

`endif

// >>> design/dspm_pkg.sv
// types shared by the multiplier block files
package dspm_pkg;
    // split of the multiplier array
    typedef enum logic [1:0] {
        DSPM_M9,
        DSPM_M18,
        DSPM_M36,
        DSPM_MRSV
    } dspm_mode_t;
    typedef logic [17:0] dspm_opnd_t;
endpackage

// >>> design/dspm_lane.sv
// one multiplier section: two 9x9 or one 18x18 product, full precision
`timescale 1ns/100ps
module dspm_lane (
    input wire logic mode9_in,
    input wire logic [17:0] a_in,
    input wire logic [17:0] b_in,
    input wire logic sign_a_in,
    input wire logic sign_b_in,
    output logic [35:0] prod_out
);
    logic signed [9:0] al;
    logic signed [9:0] ah;
    logic signed [9:0] bl;
    logic signed [9:0] bh;
    logic signed [18:0] af;
    logic signed [18:0] bf;
    logic signed [19:0] pl;
    logic signed [19:0] ph;
    logic signed [37:0] pf;

    // one extra bit carries the sign so unsigned stays positive
    assign al = {sign_a_in & a_in[8], a_in[8:0]};
    assign ah = {sign_a_in & a_in[17], a_in[17:9]};
    assign bl = {sign_b_in & b_in[8], b_in[8:0]};
    assign bh = {sign_b_in & b_in[17], b_in[17:9]};
    assign af = {sign_a_in & a_in[17], a_in};
    assign bf = {sign_b_in & b_in[17], b_in};

    assign pl = al * bl;
    assign ph = ah * bh;
    assign pf = af * bf;

    // nine-bit pairs pack two products per section
    assign prod_out = mode9_in ? {ph[17:0], pl[17:0]} : pf[35:0];
endmodule

// >>> design/dspm_top.sv
// multiplier section of a dsp slice with an axi4-lite register port
`timescale 1ns/100ps
`include "dspm_defines.svh"
module dspm_top #(
    parameter int AW = 8
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic [AW-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [AW-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [71:0] opa_in,
    input wire logic [71:0] opb_in,
    input wire logic sign_a_in,
    input wire logic sign_b_in,
    input wire logic [3:0] set_ena_in,
    input wire logic [3:0] set_clr_in,
    input wire logic [17:0] cascade_in_a_in,
    input wire logic [17:0] cascade_in_b_in,
    output logic [17:0] cascade_out_operand_a_out,
    output logic [17:0] cascade_out_operand_b_out,
    output logic [143:0] product_out,
    output logic [143:0] adder_feed_out,
    output logic result_signed_out
);
    // ----------------------------------------------------------------
    // register bus slave
    // ----------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] setsel_q;
    logic aw_got_q;
    logic w_got_q;
    logic [AW-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic wr_hit;
    logic [7:0] wa;
    logic [7:0] ra;
    logic rd_hit;
    logic [31:0] rd_data;
    logic [31:0] status;
    logic lim;

    assign wa = 8'(aw_addr_q) & 8'hFC;
    assign ra = 8'(s_axi_araddr_in) & 8'hFC;
    assign wr_fire = aw_got_q & w_got_q & !s_axi_bvalid_out;
    assign wr_hit = (wa == `DSPM_OFF_CTRL) || (wa == `DSPM_OFF_SETSEL) ||
                    (wa == `DSPM_OFF_STATUS) || (wa == `DSPM_OFF_PROD_LO) ||
                    (wa == `DSPM_OFF_PROD_HI);
    assign rd_hit = (ra == `DSPM_OFF_CTRL) || (ra == `DSPM_OFF_SETSEL) ||
                    (ra == `DSPM_OFF_STATUS) || (ra == `DSPM_OFF_PROD_LO) ||
                    (ra == `DSPM_OFF_PROD_HI);

    // write channels are taken in either order, answer follows both
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `DSPM_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_got_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_got_q <= 1'b1;
                w_data_q <= s_axi_wdata_in;
                w_strb_q <= s_axi_wstrb_in;
                s_axi_wready_out <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= wr_hit ? `DSPM_RESP_OKAY : `DSPM_RESP_SLVERR;
            end
            if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_awready_out <= 1'b1;
                s_axi_wready_out <= 1'b1;
            end
        end
    end

    // configuration registers, byte strobes honoured
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl_q <= `DSPM_CTRL_RST;
            setsel_q <= `DSPM_SETSEL_RST;
        end else if (wr_fire) begin
            for (int i = 0; i < 4; i++) begin
                if (w_strb_q[i] && wa == `DSPM_OFF_CTRL) begin
                    ctrl_q[8*i +: 8] <= w_data_q[8*i +: 8] &
                                        8'(`DSPM_CTRL_MASK >> (8*i));
                end
                if (w_strb_q[i] && wa == `DSPM_OFF_SETSEL) begin
                    setsel_q[8*i +: 8] <= w_data_q[8*i +: 8] &
                                          8'(`DSPM_SETSEL_MASK >> (8*i));
                end
            end
        end
    end

    // read answer one cycle after the address is taken
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= `DSPM_RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= rd_data;
            s_axi_rresp_out <= rd_hit ? `DSPM_RESP_OKAY : `DSPM_RESP_SLVERR;
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_arready_out <= 1'b1;
        end
    end

    // read mux, unmapped reads give zero
    always_comb begin
        rd_data = 32'h0000_0000;
        case (ra)
            `DSPM_OFF_CTRL: rd_data = ctrl_q;
            `DSPM_OFF_SETSEL: rd_data = setsel_q;
            `DSPM_OFF_STATUS: rd_data = status;
            `DSPM_OFF_PROD_LO: rd_data = product_out[31:0] |
                                         adder_feed_out[31:0];
            `DSPM_OFF_PROD_HI: rd_data = {28'h000_0000,
                product_out[35:32] | adder_feed_out[35:32]};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // configuration decode
    // ----------------------------------------------------------------
    dspm_pkg::dspm_mode_t mode;
    logic m9;
    logic m36;
    logic shift_on;
    logic [1:0] tap;

    assign mode = dspm_pkg::dspm_mode_t'(
        ctrl_q[`DSPM_CTRL_MODE_MSB:`DSPM_CTRL_MODE_LSB]);
    assign m9 = (mode == dspm_pkg::DSPM_M9);
    assign m36 = (mode == dspm_pkg::DSPM_M36);
    // no shift chain in the wide mode
    assign shift_on = ctrl_q[`DSPM_CTRL_SHIFT] & !m36;
    assign tap = ctrl_q[`DSPM_CTRL_TAP_MSB:`DSPM_CTRL_TAP_LSB];
    assign status = {27'h000_0000, lim, mode, shift_on, result_signed_out};

    // ----------------------------------------------------------------
    // sign controls
    // ----------------------------------------------------------------
    logic sa_q;
    logic sb_q;
    logic sign_en;
    logic sa_eff;
    logic sb_eff;

    assign sign_en = set_ena_in[setsel_q[1:0]];
    // sign captured alongside the first a input set
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sa_q <= 1'b0;
            sb_q <= 1'b0;
        end else if (sign_en) begin
            sa_q <= sign_a_in;
            sb_q <= sign_b_in;
        end
    end
    assign sa_eff = ctrl_q[`DSPM_CTRL_SIGNREG] ? sa_q : sign_a_in;
    assign sb_eff = ctrl_q[`DSPM_CTRL_SHARED] ? sa_eff :
                    ctrl_q[`DSPM_CTRL_SIGNREG] ? sb_q : sign_b_in;

    // ----------------------------------------------------------------
    // input registers and section multipliers
    // ----------------------------------------------------------------
    dspm_pkg::dspm_opnd_t opa_q [4];
    dspm_pkg::dspm_opnd_t opb_q [4];
    dspm_pkg::dspm_opnd_t opa_d [4];
    dspm_pkg::dspm_opnd_t opb_d [4];
    dspm_pkg::dspm_opnd_t opa_use [4];
    dspm_pkg::dspm_opnd_t opb_use [4];
    logic [143:0] lane_cat;

    for (genvar k = 0; k < 4; k++) begin : g_sec
        logic [1:0] sel_a;
        logic [1:0] sel_b;
        logic en_a;
        logic en_b;
        logic clr_a;
        logic clr_b;
        logic chain_a;
        logic chain_b;
        logic [17:0] up_a;
        logic [17:0] up_b;
        logic [17:0] src_a;
        logic [17:0] src_b;
        logic [35:0] lane_p;

        // each set picks its own enable and clear
        assign sel_a = setsel_q[4*k +: 2];
        assign sel_b = setsel_q[4*k+2 +: 2];
        assign en_a = set_ena_in[sel_a];
        assign en_b = set_ena_in[sel_b];
        assign clr_a = set_clr_in[sel_a];
        assign clr_b = set_clr_in[sel_b];
        if (k == 0) begin : g_head
            assign up_a = cascade_in_a_in;
            assign up_b = cascade_in_b_in;
        end else begin : g_link
            assign up_a = opa_q[k-1];
            assign up_b = opb_q[k-1];
        end
        // a parallel operand stays off the chain
        assign chain_a = shift_on & !ctrl_q[`DSPM_CTRL_PAR_A];
        // coefficients shift or load in parallel
        assign chain_b = shift_on & !ctrl_q[`DSPM_CTRL_PAR_B];
        // nine-bit slots move one slot per enable
        assign src_a = !chain_a ? opa_in[18*k +: 18] :
                       m9 ? {opa_q[k][8:0], up_a[17:9]} : up_a;
        assign src_b = !chain_b ? opb_in[18*k +: 18] :
                       m9 ? {opb_q[k][8:0], up_b[17:9]} : up_b;
        assign opa_d[k] = clr_a ? 18'h0_0000 : en_a ? src_a : opa_q[k];
        assign opb_d[k] = clr_b ? 18'h0_0000 : en_b ? src_b : opb_q[k];

        always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                opa_q[k] <= 18'h0_0000;
                opb_q[k] <= 18'h0_0000;
            end else begin
                opa_q[k] <= opa_d[k];
                opb_q[k] <= opb_d[k];
            end
        end
        // register is bypassed unless enabled or chained
        assign opa_use[k] = (ctrl_q[`DSPM_CTRL_INA] | chain_a) ?
                            opa_q[k] : opa_in[18*k +: 18];
        assign opb_use[k] = (ctrl_q[`DSPM_CTRL_INB] | chain_b) ?
                            opb_q[k] : opb_in[18*k +: 18];

        dspm_lane u_lane (
            .mode9_in(m9),
            .a_in(opa_use[k]),
            .b_in(opb_use[k]),
            .sign_a_in(sa_eff),
            .sign_b_in(sb_eff),
            .prod_out(lane_p)
        );
        assign lane_cat[36*k +: 36] = lane_p;
    end

    // ----------------------------------------------------------------
    // wide multiply across sections 0 and 1
    // ----------------------------------------------------------------
    logic [35:0] a36;
    logic [35:0] b36;
    logic [35:0] a36t;
    logic [35:0] b36t;
    logic signed [36:0] a37;
    logic signed [36:0] b37;
    logic signed [73:0] p74;
    logic [143:0] mul_raw;

    // differing separate signs narrow both to 35 bits
    assign lim = m36 & !ctrl_q[`DSPM_CTRL_SHARED] & (sa_eff != sb_eff);
    assign a36 = {opa_use[1], opa_use[0]};
    assign b36 = {opb_use[1], opb_use[0]};
    // top bit becomes the extension of bit 34
    assign a36t = lim ? {sa_eff & a36[34], a36[34:0]} : a36;
    assign b36t = lim ? {sb_eff & b36[34], b36[34:0]} : b36;
    assign a37 = {sa_eff & a36t[35], a36t};
    assign b37 = {sb_eff & b36t[35], b36t};
    assign p74 = a37 * b37;
    // one wide product or four section products
    assign mul_raw = m36 ? {72'h0, p74[71:0]} : lane_cat;

    // ----------------------------------------------------------------
    // pipeline and output stage
    // ----------------------------------------------------------------
    logic [143:0] pipe_q;
    logic rs_pipe_q;
    logic [143:0] pipe_sel;
    logic rs_sel;
    logic route;

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pipe_q <= '0;
            rs_pipe_q <= 1'b0;
        end else begin
            pipe_q <= mul_raw;
            rs_pipe_q <= sa_eff | sb_eff;
        end
    end
    assign pipe_sel = ctrl_q[`DSPM_CTRL_PIPE] ? pipe_q : mul_raw;
    // signed if either operand is signed
    assign rs_sel = ctrl_q[`DSPM_CTRL_PIPE] ? rs_pipe_q : (sa_eff | sb_eff);
    assign route = ctrl_q[`DSPM_CTRL_ROUTE];

    // products go out or to the adder stage, never both
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            product_out <= '0;
            adder_feed_out <= '0;
            result_signed_out <= 1'b0;
        end else begin
            product_out <= route ? '0 : pipe_sel;
            adder_feed_out <= route ? pipe_sel : '0;
            result_signed_out <= rs_sel;
        end
    end

    // cascade outputs mirror the tapped registers
    // tap chooses where the chain ends
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cascade_out_operand_a_out <= 18'h0_0000;
            cascade_out_operand_b_out <= 18'h0_0000;
        end else begin
            cascade_out_operand_a_out <= opa_d[tap];
            cascade_out_operand_b_out <= opb_d[tap];
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    AST_SIGNED_RESULT: assert property (
        !ctrl_q[`DSPM_CTRL_PIPE] && $stable(ctrl_q) |=>
        result_signed_out == $past(sa_eff | sb_eff))
        else $error("result sign does not follow operand signs");
    AST_CLEAR_WINS: assert property (
        set_clr_in[setsel_q[1:0]] |=> opa_q[0] == 18'h0_0000)
        else $error("selected clear did not zero the register");
    AST_HOLD: assert property (
        !set_clr_in[setsel_q[5:4]] && !set_ena_in[setsel_q[5:4]] |=>
        $stable(opa_q[1]))
        else $error("input register moved without enable");
    AST_PAR_LOAD: assert property (
        !shift_on && set_ena_in[setsel_q[3:2]] &&
        !set_clr_in[setsel_q[3:2]] |=> opb_q[0] == $past(opb_in[17:0]))
        else $error("parallel load missed routing data");
    AST_SHIFT_ADV: assert property (
        shift_on && !m9 && !ctrl_q[`DSPM_CTRL_PAR_A] &&
        set_ena_in[setsel_q[5:4]] && !set_clr_in[setsel_q[5:4]]
        |=> opa_q[1] == $past(opa_q[0]))
        else $error("chain did not advance one section");
    AST_TAP: assert property (
        1'b1 |=> cascade_out_operand_a_out == opa_q[$past(tap)])
        else $error("cascade output differs from tapped register");
    AST_ROUTE: assert property (
        route && $stable(ctrl_q) |=> product_out == '0 &&
        adder_feed_out == $past(pipe_sel))
        else $error("routed product leaked to the output");
    AST_MUL18: assert property (
        mode == dspm_pkg::DSPM_M18 && ctrl_q[10:2] == 9'h000 &&
        !sign_a_in && !sign_b_in |=>
        product_out[35:0] == $past(opa_in[17:0]) * $past(opb_in[17:0]))
        else $error("unsigned 18x18 product wrong");
    AST_LIMIT: assert property (
        m36 && !ctrl_q[`DSPM_CTRL_SHARED] && sa_eff && !sb_eff |->
        lim && a36t[35] == a36[34] && !b36t[35])
        else $error("mixed wide multiply not narrowed");
    AST_BRESP: assert property (
        wr_fire |=> s_axi_bvalid_out ##0 s_axi_bvalid_out [*1])
        else $error("write answer late");

    COV_SHIFT: cover property (shift_on && set_ena_in[setsel_q[1:0]]);
    COV_WIDE: cover property (m36 ##1 product_out[71:36] != 36'h0);
    COV_ROUTE: cover property (route ##1 adder_feed_out != '0);
    COV_WRITE: cover property (s_axi_bvalid_out && s_axi_bready_in);
endmodule

// >>> test/dspm_fabric.sv
// fabric-side model: operands, sign controls, shared sets, cascade feed
`timescale 1ns/100ps
module dspm_fabric (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic step_in,
    output logic [71:0] opa_out,
    output logic [71:0] opb_out,
    output logic sign_a_out,
    output logic sign_b_out,
    output logic [3:0] set_ena_out,
    output logic [3:0] set_clr_out,
    output logic [17:0] cas_a_out,
    output logic [17:0] cas_b_out
);
    integer seed = 32'hE3D224B6;
    // --------------------------------------------------------------
    // operand source
    // --------------------------------------------------------------
    // sign levels
    // words change only on a step so that products can settle
    always @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            opa_out <= 72'h0;
            opb_out <= 72'h0;
            {sign_a_out, sign_b_out} <= 2'h0;
            {cas_a_out, cas_b_out} <= 36'h0;
            set_ena_out <= 4'h8;
            set_clr_out <= 4'h0;
        end else begin
            // shared sets
            // set 3 stays open for the checked section, sets 0-2 wander
            set_ena_out <= {1'h1, 3'($random(seed))};
            set_clr_out <= {1'h0, 3'($random(seed) & $random(seed))};
            if (step_in) begin
                opa_out <= 72'({$random(seed), $random(seed), $random(seed)});
                opb_out <= 72'({$random(seed), $random(seed), $random(seed)});
                {sign_a_out, sign_b_out} <= 2'($random(seed));
                // outer shift
                // cascade feed is noise: never relied on in 36x36 use
                {cas_a_out, cas_b_out} <= 36'({$random(seed), $random(seed)});
            end
        end
    end
endmodule

// >>> test/dspm_top_tb.sv
// self-checking bench for the multiplier block
`timescale 1ns/100ps
module dspm_top_tb;
    logic clk_sys_in = 1'h0;
    logic sys_rst_in = 1'h1;
    logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
    logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
    logic [3:0] s_axi_wstrb_in = 4'hF, set_ena_in, set_clr_in;
    logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0;
    logic s_axi_bready_in = 1'h0, s_axi_arvalid_in = 1'h0;
    logic s_axi_rready_in = 1'h0, step = 1'h0, pp, sign_a_in, sign_b_in;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
    logic s_axi_arready_out, s_axi_rvalid_out, result_signed_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, m;
    logic [71:0] opa_in, opb_in;
    logic [17:0] cascade_in_a_in, cascade_in_b_in;
    logic [17:0] cascade_out_operand_a_out, cascade_out_operand_b_out;
    logic [35:0] cq[$];
    logic [143:0] product_out, adder_feed_out;
    logic [288:0] exp_p, pq[$];
    logic [33:0] rq[$];
    int num_errors = 0, total_checks = 0;

    dspm_top #(.AW(8)) DUT (.clk_sys_in, .sys_rst_in, .s_axi_awaddr_in,
        .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in,
        .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
        .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
        .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
        .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
        .s_axi_rready_in, .opa_in, .opb_in, .sign_a_in, .sign_b_in,
        .set_ena_in, .set_clr_in, .cascade_in_a_in, .cascade_in_b_in,
        .cascade_out_operand_a_out, .cascade_out_operand_b_out,
        .product_out, .adder_feed_out, .result_signed_out);
    dspm_fabric fab (.clk_sys_in, .sys_rst_in, .step_in(step),
        .opa_out(opa_in), .opb_out(opb_in), .sign_a_out(sign_a_in),
        .sign_b_out(sign_b_in), .set_ena_out(set_ena_in),
        .set_clr_out(set_clr_in), .cas_a_out(cascade_in_a_in),
        .cas_b_out(cascade_in_b_in));

    // --------------------------------------------------------------
    // reference arithmetic
    // --------------------------------------------------------------
    // modular product of sign-extended operands, trimmed to 2w bits
    function automatic logic [71:0] mul(logic [35:0] a, b, logic sa, sb,
                                        int w);
        logic [71:0] x, y;
        x = 72'(a);
        y = 72'(b);
        for (int i = w; i < 72; i++) begin
            x[i] = sa & a[w-1];
            y[i] = sb & b[w-1];
        end
        x = x * y;
        for (int i = 2 * w; i < 72; i++) x[i] = 1'h0;
        return x;
    endfunction
    function automatic logic [288:0] calc(logic [1:0] md, logic rt);
        logic [143:0] p;
        logic sa, sb;
        sa = sign_a_in;
        sb = (md == 2'h2) ? sign_a_in : sign_b_in; // shared control in 36x36
        p = 144'h0;
        for (int k = 0; k < 4; k++) begin
            if (md == 2'h0) begin
                p[36*k+18+:18] = 18'(mul(36'(opa_in[18*k+9+:9]),
                    36'(opb_in[18*k+9+:9]), sa, sb, 9));
                p[36*k+:18] = 18'(mul(36'(opa_in[18*k+:9]),
                    36'(opb_in[18*k+:9]), sa, sb, 9));
            end else
                p[36*k+:36] = 36'(mul(36'(opa_in[18*k+:18]),
                    36'(opb_in[18*k+:18]), sa, sb, 18));
        end
        if (md == 2'h2)
            p = {72'h0, mul(opa_in[35:0], opb_in[35:0], sa, sb, 36)};
        return rt ? {sa | sb, p, 144'h0} : {sa | sb, 144'h0, p};
    endfunction

    // --------------------------------------------------------------
    // checking and closing
    // --------------------------------------------------------------
    task automatic cmp(input logic [288:0] seen, input logic [288:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && total_checks > 0 && pq.size() + cq.size() == 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // bus answers, oldest note first; sampled before the edge lands
    always @(posedge clk_sys_in) begin
        if (s_axi_bvalid_out && s_axi_bready_in)
            cmp({s_axi_bresp_out, 32'h0}, rq.pop_front());
        if (s_axi_rvalid_out && s_axi_rready_in)
            cmp({s_axi_rresp_out, s_axi_rdata_out}, rq.pop_front());
    end
    // products looked at mid-cycle, when settled
    always @(negedge clk_sys_in) begin
        if (pq.size() > 0)
            cmp({result_signed_out, adder_feed_out, product_out},
                pq.pop_front());
        if (cq.size() > 0)
            cmp({cascade_out_operand_a_out, cascade_out_operand_b_out},
                cq.pop_front());
    end

    // --------------------------------------------------------------
    // drivers
    // --------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        logic ta, tw;
        ta = 1'h0;
        tw = 1'h0;
        rq.push_back({r, 32'h0});
        @(posedge clk_sys_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
        while (!(ta && tw)) begin
            @(posedge clk_sys_in);
            if (s_axi_awready_out) ta = 1'h1;
            if (s_axi_wready_out) tw = 1'h1;
            if (ta) s_axi_awvalid_in <= 1'h0;
            if (tw) s_axi_wvalid_in <= 1'h0;
        end
        @(posedge clk_sys_in);
        while (!s_axi_bvalid_out) @(posedge clk_sys_in);
        s_axi_bready_in <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        rq.push_back({r, d});
        @(posedge clk_sys_in);
        s_axi_araddr_in <= a;
        {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
        @(posedge clk_sys_in);
        while (!s_axi_arready_out) @(posedge clk_sys_in);
        s_axi_arvalid_in <= 1'h0;
        @(posedge clk_sys_in);
        while (!s_axi_rvalid_out) @(posedge clk_sys_in);
        s_axi_rready_in <= 1'h0;
    endtask
    // exact latency
    // one new operand set; with the pipe on, the old product stands a cycle
    task automatic go(input int lat, input bit old);
        logic [288:0] nxt;
        @(posedge clk_sys_in) step <= 1'h1;
        @(posedge clk_sys_in) step <= 1'h0;
        #1;
        nxt = calc(m, pp);
        repeat (lat - 1) begin
            @(posedge clk_sys_in);
            #1;
            if (old) pq.push_back(exp_p);
        end
        @(posedge clk_sys_in);
        #1;
        exp_p = nxt;
        pq.push_back(exp_p);
        // tapped section 3 holds the last routing word
        cq.push_back({opa_in[71:54], opb_in[71:54]});
    endtask

    always #5 clk_sys_in = ~clk_sys_in;
    initial begin
        #200000;
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge clk_sys_in);
        sys_rst_in <= 1'h0;
        rd(8'h00, 32'h0000_0001, 2'h0);
        rd(8'h04, 32'h0000_0000, 2'h0);
        rd(8'h14, 32'h0000_0000, 2'h2);
        wr(8'h14, 32'hFFFF_FFFF, 2'h2);
        wr(8'h04, 32'hFFFF_FFFF, 2'h0);
        rd(8'h04, 32'h0000_FFFF, 2'h0);
        wr(8'h00, 32'hFFFF_FFFF, 2'h0);
        rd(8'h00, 32'h0000_37FF, 2'h0);
        // sections 0-2 on a wandering set, 3 on a steady one
        wr(8'h04, 32'h0000_F000, 2'h0);
        // every split
        // each split with pipe and adder routing off, then both on
        for (int c = 0; c < 6; c++) begin
            m = 2'(c % 3);
            pp = (c > 2);
            wr(8'h00, {18'h0, 2'h3, 1'h0, pp, m == 2'h2, 1'h0, pp, 5'h0,
                m}, 2'h0);
            go(1 + pp, 1'b0);
            repeat (5) go(1 + pp, 1'b1);
        end
        // chain a shifts, b stays parallel
        wr(8'h00, 32'h0000_3051, 2'h0);
        repeat (40) @(posedge clk_sys_in);
        end_of_test();
    end
endmodule
